// [seu_defines.vh]
// Register map, field positions and timing counts for the exception and low-power unit.
// How it works
// - Interrupts taken at instruction boundaries or on wake
// - Take irq if mask clear and enabled
// - Highest pending priority wins, also at return
// - Fixed priority flag 1 highest, 20 lowest
// - Stack all registers except high index
// - Software interrupt ignores mask, stacks PC
// - Status one: flags 1-6 high, low bits zero
// - Status two: flags 14 down to 7
// - Status three: top zero, flags 20-15
// - Resets equal priority above all interrupts
// - Break forces software interrupt vector fetch
// - Break protects flags unless clear enable set
// - Two-step clears stay protected during break
// - Wait or stop clears mask, stops CPU
// - Wait: peripherals run, interrupt wakes CPU
// - Wait exits on reset, break sets flag
// - Stop resets counter, gates both clocks
// - Recovery 4096 cycles, or 32 if short
// - Counter held reset until recovery begins
// - Three registers at fixed addresses, gap
// - Reset cause cleared by read, power-on
// - Separate flag per reset cause
`ifndef SEU_DEFINES_VH
`define SEU_DEFINES_VH
`define SEU_ADDR_BRK_STATUS   16'hFE00
`define SEU_ADDR_RST_CAUSE    16'hFE01
`define SEU_ADDR_BRK_FLAG_CTL 16'hFE03
`define SEU_ADDR_IRQ_ONE      16'hFE04
`define SEU_ADDR_IRQ_TWO      16'hFE05
`define SEU_ADDR_IRQ_THREE    16'hFE06
`define SEU_ADDR_IRQ_ENABLE   16'hFE08
`define SEU_BIT_EXITED_WAIT   1
`define SEU_BIT_CLEAR_ENABLE  7
`define SEU_BIT_POWER_ON      7
`define SEU_BIT_PIN           6
`define SEU_BIT_WATCHDOG      5
`define SEU_BIT_ILL_OPCODE    4
`define SEU_BIT_ILL_ADDRESS   3
`define SEU_BIT_MONITOR       2
`define SEU_BIT_LOW_VOLTAGE   1
`define SEU_RST_CAUSE_POR     8'h80
`define SEU_IRQ_ENABLE_RESET  20'hFFFFF
`define SEU_RECOVERY_LONG     13'h1000
`define SEU_RECOVERY_SHORT    13'h0020
`define SEU_VECTOR_NONE       5'h00
`define SEU_VECTOR_SWI        5'h1F
`endif

// [seu_exception_lowpower.v]
// Exception arbitration, low-power sequencing and break-mode register block.
//
// The Avalon-MM slave port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "seu_defines.vh"
module seu_exception_lowpower #(
    parameter NUM_IRQ = 20,
    parameter CNT_W   = 13
) (
    // Clock and reset
    input  wire                 core_clk,
    input  wire                 rst,
    // Avalon-MM slave
    input  wire [15:0]          avs_address,
    input  wire                 avs_read,
    input  wire                 avs_write,
    input  wire [7:0]           avs_writedata,
    output reg  [7:0]           avs_readdata,
    output wire                 avs_waitrequest,
    // Reset sources
    input  wire                 por_event,
    input  wire                 pin_reset_event,
    input  wire                 watchdog_reset_event,
    input  wire                 ill_opcode_event,
    input  wire                 ill_address_event,
    input  wire                 monitor_reset_event,
    input  wire                 low_voltage_event,
    output wire                 reset_request,
    // CPU core side
    input  wire                 instr_boundary,
    input  wire                 global_mask,
    input  wire                 swi_exec,
    input  wire                 wait_exec,
    input  wire                 stop_exec,
    input  wire                 break_irq,
    input  wire                 short_stop_recovery_option,
    input  wire [NUM_IRQ-1:0]   irq_request,
    output reg                  take_exception,
    output reg  [4:0]           vector_sel,
    output reg                  stack_pc_minus_one,
    output wire                 stack_high_index,
    output reg                  clear_global_mask,
    output reg                  in_break,
    output wire                 flag_clear_allow,
    output wire                 cpu_clk_en,
    output wire                 periph_clk_en
);
    localparam ST_RUN  = 4'b0001;
    localparam ST_WAIT = 4'b0010;
    localparam ST_STOP = 4'b0100;
    localparam ST_REC  = 4'b1000;

    reg  [3:0]         state_ff;
    reg  [3:0]         nxt_state;
    reg  [CNT_W-1:0]   rec_cnt_ff;
    reg  [CNT_W-1:0]   nxt_rec_cnt;
    reg  [7:0]         rst_cause_ff;
    reg                exited_wait_ff;
    reg                clear_enable_ff;
    reg  [NUM_IRQ-1:0] irq_enable_ff;
    reg                rd_done_ff;
    wire [NUM_IRQ-1:0] eligible;
    reg  [4:0]         win_idx;
    reg                win_valid;
    wire               any_reset;
    wire               rd_cause;
    wire               wake_irq;
    integer            i;

    // Single-cycle answer for writes; reads wait one cycle for registered data.
    assign avs_waitrequest = avs_read & ~rd_done_ff;

    assign any_reset = por_event | pin_reset_event | watchdog_reset_event
                     | ill_opcode_event | ill_address_event
                     | monitor_reset_event | low_voltage_event;
    // All causes collapse onto one request with no arbitration between them.
    assign reset_request = any_reset;

    assign stack_high_index = 1'b0;
    assign flag_clear_allow = ~in_break | clear_enable_ff;

    assign eligible = irq_request & irq_enable_ff;
    assign wake_irq = |eligible;

    // Lowest index wins, so flag 1 outranks flag 20.
    always @* begin
        win_idx   = 5'h00;
        win_valid = 1'b0;
        for (i = NUM_IRQ - 1; i >= 0; i = i - 1) begin
            if (eligible[i]) begin
                win_idx   = i[4:0] + 5'h01;
                win_valid = 1'b1;
            end
        end
    end

    assign cpu_clk_en    = (state_ff == ST_RUN);
    assign periph_clk_en = (state_ff == ST_RUN) | (state_ff == ST_WAIT);

    always @* begin
        nxt_state   = state_ff;
        nxt_rec_cnt = rec_cnt_ff;
        case (state_ff)
            ST_RUN: begin
                if (wait_exec) begin
                    nxt_state = ST_WAIT;
                end else if (stop_exec) begin
                    nxt_state   = ST_STOP;
                    nxt_rec_cnt = {CNT_W{1'b0}};
                end
            end
            ST_WAIT: begin
                if (wake_irq | break_irq) begin
                    nxt_state = ST_RUN;
                end
            end
            ST_STOP: begin
                nxt_rec_cnt = {CNT_W{1'b0}};
                if (wake_irq | break_irq) begin
                    nxt_state = ST_REC;
                end
            end
            ST_REC: begin
                nxt_rec_cnt = rec_cnt_ff + {{(CNT_W-1){1'b0}}, 1'b1};
                if (short_stop_recovery_option) begin
                    if (nxt_rec_cnt == `SEU_RECOVERY_SHORT) begin
                        nxt_state = ST_RUN;
                    end
                end else if (nxt_rec_cnt == `SEU_RECOVERY_LONG) begin
                    nxt_state = ST_RUN;
                end
            end
            default: begin
                nxt_state = ST_RUN;
            end
        endcase
        // Reset exits any low-power mode at once.
        if (any_reset) begin
            nxt_state   = ST_RUN;
            nxt_rec_cnt = {CNT_W{1'b0}};
        end
    end

    assign rd_cause = avs_read & ~rd_done_ff
                    & (avs_address == `SEU_ADDR_RST_CAUSE);

    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_ff           <= ST_RUN;
            rec_cnt_ff         <= {CNT_W{1'b0}};
            exited_wait_ff     <= 1'b0;
            take_exception     <= 1'b0;
            vector_sel         <= `SEU_VECTOR_NONE;
            stack_pc_minus_one <= 1'b0;
            clear_global_mask  <= 1'b0;
            in_break           <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            rec_cnt_ff <= nxt_rec_cnt;

            clear_global_mask <= (state_ff == ST_RUN)
                               & (wait_exec | stop_exec);

            // Exceptions are offered only at a boundary or on wake.
            take_exception     <= 1'b0;
            stack_pc_minus_one <= 1'b0;
            if (any_reset) begin
                take_exception <= 1'b0;
            end else if (break_irq & (instr_boundary
                         | state_ff == ST_WAIT)) begin
                take_exception <= 1'b1;
                vector_sel     <= `SEU_VECTOR_SWI;
                in_break       <= 1'b1;
            end else if (swi_exec & instr_boundary) begin
                take_exception <= 1'b1;
                vector_sel     <= `SEU_VECTOR_SWI;
            end else if (win_valid & ~global_mask & instr_boundary
                         & state_ff == ST_RUN) begin
                take_exception     <= 1'b1;
                vector_sel         <= win_idx;
                stack_pc_minus_one <= 1'b1;
            end else if (win_valid & (state_ff == ST_WAIT)) begin
                // Stacking starts on the same edge that returns the core to ST_RUN.
                take_exception     <= 1'b1;
                vector_sel         <= win_idx;
                stack_pc_minus_one <= 1'b1;
            end else if (win_valid & (state_ff == ST_REC)
                         & (nxt_state == ST_RUN)) begin
                take_exception     <= 1'b1;
                vector_sel         <= win_idx;
                stack_pc_minus_one <= 1'b1;
            end

            // Break ends with the return from its handler; the core reports it
            // as an instruction boundary with no break request.
            if (in_break & instr_boundary & ~break_irq & ~swi_exec) begin
                in_break <= 1'b0;
            end

            if (break_irq & (state_ff == ST_WAIT)) begin
                exited_wait_ff <= 1'b1;
            end else if (avs_write & ~avs_waitrequest
                         & avs_address == `SEU_ADDR_BRK_STATUS
                         & ~avs_writedata[`SEU_BIT_EXITED_WAIT]) begin
                exited_wait_ff <= 1'b0;
            end

        end
    end

    // Cause flags live apart from the exception logic, so that a new cause
    // and a clearing read are weighed in one place.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rst_cause_ff <= `SEU_RST_CAUSE_POR;
        end else begin
            // A new cause wins over a clearing read in the same cycle.
            if (por_event) begin
                rst_cause_ff <= `SEU_RST_CAUSE_POR;
            end else if (any_reset) begin
                rst_cause_ff[`SEU_BIT_PIN]         <= pin_reset_event;
                rst_cause_ff[`SEU_BIT_WATCHDOG]    <= watchdog_reset_event;
                rst_cause_ff[`SEU_BIT_ILL_OPCODE]  <= ill_opcode_event;
                rst_cause_ff[`SEU_BIT_ILL_ADDRESS] <= ill_address_event;
                rst_cause_ff[`SEU_BIT_MONITOR]     <= monitor_reset_event;
                rst_cause_ff[`SEU_BIT_LOW_VOLTAGE] <= low_voltage_event;
                rst_cause_ff[`SEU_BIT_POWER_ON]    <= 1'b0;
            end else if (rd_cause) begin
                rst_cause_ff <= 8'h00;
            end
        end
    end

    // Software-written control bits; writes never stall.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clear_enable_ff <= 1'b0;
            irq_enable_ff   <= `SEU_IRQ_ENABLE_RESET;
        end else begin
            if (avs_write) begin
                if (avs_address == `SEU_ADDR_BRK_FLAG_CTL) begin
                    clear_enable_ff <= avs_writedata[`SEU_BIT_CLEAR_ENABLE];
                end else if (avs_address == `SEU_ADDR_IRQ_ENABLE) begin
                    irq_enable_ff[7:0] <= avs_writedata;
                end else if (avs_address == `SEU_ADDR_IRQ_ENABLE + 16'h0001) begin
                    irq_enable_ff[15:8] <= avs_writedata;
                end else if (avs_address == `SEU_ADDR_IRQ_ENABLE + 16'h0002) begin
                    irq_enable_ff[19:16] <= avs_writedata[3:0];
                end
                // Pending flag registers take no writes.
            end
        end
    end

    // Read data is registered on the first edge of a read, so it already
    // stands when waitrequest falls and the master takes it.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rd_done_ff   <= 1'b0;
            avs_readdata <= 8'h00;
        end else begin
            rd_done_ff <= avs_read & ~rd_done_ff;
            if (avs_read & ~rd_done_ff) begin
                if (avs_address == `SEU_ADDR_BRK_STATUS) begin
                    avs_readdata <= {6'h00, exited_wait_ff, 1'b0};
                end else if (avs_address == `SEU_ADDR_RST_CAUSE) begin
                    avs_readdata <= rst_cause_ff;
                end else if (avs_address == `SEU_ADDR_BRK_FLAG_CTL) begin
                    avs_readdata <= {clear_enable_ff, 7'h00};
                end else if (avs_address == `SEU_ADDR_IRQ_ONE) begin
                    avs_readdata <= {irq_request[5:0], 2'b00};
                end else if (avs_address == `SEU_ADDR_IRQ_TWO) begin
                    avs_readdata <= irq_request[13:6];
                end else if (avs_address == `SEU_ADDR_IRQ_THREE) begin
                    avs_readdata <= {2'b00, irq_request[19:14]};
                end else if (avs_address == `SEU_ADDR_IRQ_ENABLE) begin
                    avs_readdata <= irq_enable_ff[7:0];
                end else if (avs_address == `SEU_ADDR_IRQ_ENABLE + 16'h0001) begin
                    avs_readdata <= irq_enable_ff[15:8];
                end else if (avs_address == `SEU_ADDR_IRQ_ENABLE + 16'h0002) begin
                    avs_readdata <= {4'h0, irq_enable_ff[19:16]};
                end else begin
                    avs_readdata <= 8'h00;
                end
            end
        end
    end
endmodule
`default_nettype wire

// [seu_exc_monitor.sv]
// Concurrent checks on the exception and low-power unit's ports.
`timescale 1ns/100ps
`default_nettype none
module seu_exc_monitor #(
    parameter NUM_IRQ = 20
) (
    // Clock, reset and bus
    input wire logic               core_clk,
    input wire logic               rst,
    input wire logic               avs_read,
    input wire logic               avs_waitrequest,
    // Core side inputs
    input wire logic               instr_boundary,
    input wire logic               global_mask,
    input wire logic               swi_exec,
    input wire logic               wait_exec,
    input wire logic               stop_exec,
    input wire logic               break_irq,
    input wire logic               short_stop_recovery_option,
    input wire logic [NUM_IRQ-1:0] irq_request,
    // Outputs under check
    input wire logic               take_exception,
    input wire logic               stack_pc_minus_one,
    input wire logic               stack_high_index,
    input wire logic               clear_global_mask,
    input wire logic               in_break,
    input wire logic               flag_clear_allow,
    input wire logic               cpu_clk_en,
    input wire logic               periph_clk_en,
    input wire logic               reset_request,
    input wire logic [4:0]         vector_sel
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    int lp_cnt;
    // Recovery can only be judged by how long the core stayed unclocked.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            lp_cnt <= 0;
        end else if (cpu_clk_en) begin
            lp_cnt <= 0;
        end else begin
            lp_cnt <= lp_cnt + 1;
        end
    end
    sequence s_bnd;
        instr_boundary && cpu_clk_en && !reset_request && !break_irq
            && !wait_exec && !stop_exec;
    endsequence
    sequence s_rd;
        avs_waitrequest ##1 !avs_waitrequest;
    endsequence
    property p_irq;
        s_bnd ##0 (!swi_exec && !global_mask && irq_request[0])
            |=> take_exception && stack_pc_minus_one && vector_sel == 5'h01;
    endproperty
    a_irq: assert property (p_irq) else $error("flag one not taken");
    property p_mask;
        s_bnd ##0 (!swi_exec && global_mask) |=> !take_exception;
    endproperty
    a_mask: assert property (p_mask) else $error("masked irq taken");
    property p_swi;
        s_bnd ##0 swi_exec
            |=> take_exception && !stack_pc_minus_one && vector_sel == 5'h1F;
    endproperty
    a_swi: assert property (p_swi) else $error("swi not taken");
    property p_brk;
        break_irq && !in_break && !cpu_clk_en && periph_clk_en
            && !reset_request |-> ##[1:2] (in_break && vector_sel == 5'h1F);
    endproperty
    a_brk: assert property (p_brk) else $error("break not entered");
    property p_lowpwr;
        (wait_exec || stop_exec) && cpu_clk_en && !reset_request && !swi_exec
            && !break_irq && (global_mask || !(|irq_request))
            |=> clear_global_mask && !cpu_clk_en
            && periph_clk_en == $past(wait_exec);
    endproperty
    a_lowpwr: assert property (p_lowpwr) else $error("bad low power entry");
    property p_clr;
        !in_break |-> flag_clear_allow;
    endproperty
    a_clr: assert property (p_clr) else $error("clear blocked outside break");
    property p_hi;
        !stack_high_index;
    endproperty
    a_hi: assert property (p_hi) else $error("high index stacked");
    property p_rec;
        $rose(cpu_clk_en) && !$past(periph_clk_en) && !$past(reset_request)
            |-> lp_cnt >= (short_stop_recovery_option ? 32 : 4096);
    endproperty
    a_rec: assert property (p_rec) else $error("stop recovery too short");
    property p_rd;
        $rose(avs_read) |-> s_rd;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer late");
endmodule
bind seu_exception_lowpower seu_exc_monitor #(.NUM_IRQ(NUM_IRQ)) u_mon (
    .core_clk(core_clk), .rst(rst), .avs_read(avs_read),
    .avs_waitrequest(avs_waitrequest), .instr_boundary(instr_boundary),
    .global_mask(global_mask), .swi_exec(swi_exec), .wait_exec(wait_exec),
    .stop_exec(stop_exec), .break_irq(break_irq),
    .short_stop_recovery_option(short_stop_recovery_option),
    .irq_request(irq_request), .take_exception(take_exception),
    .stack_pc_minus_one(stack_pc_minus_one),
    .stack_high_index(stack_high_index),
    .clear_global_mask(clear_global_mask), .in_break(in_break),
    .flag_clear_allow(flag_clear_allow), .cpu_clk_en(cpu_clk_en),
    .periph_clk_en(periph_clk_en), .reset_request(reset_request),
    .vector_sel(vector_sel)
);
`default_nettype wire

// [seu_core_model.sv]
// Core stand-in that ends instructions and issues swi, wait and stop.
`timescale 1ns/100ps
`default_nettype none
module seu_core_model (
    // Clock, reset and status
    input wire logic core_clk, rst, cpu_clk_en, take_exception,
    // Opcode chosen by the bench
    input wire logic [1:0] op_cmd,
    // Core outputs
    output logic instr_boundary, swi_exec, wait_exec, stop_exec
);
    logic [1:0] phase_ff;
    // Stacking is not an instruction end, so entry restarts the phase.
    always @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase_ff <= 2'h0;
        end else if (take_exception) begin
            phase_ff <= 2'h0;
        end else if (cpu_clk_en) begin
            phase_ff <= phase_ff + 2'h1;
        end
    end
    assign instr_boundary = cpu_clk_en && !take_exception && phase_ff == 2'h3;
    assign swi_exec = instr_boundary && op_cmd == 2'h1;
    assign wait_exec = instr_boundary && op_cmd == 2'h2;
    assign stop_exec = instr_boundary && op_cmd == 2'h3;
endmodule
`default_nettype wire

// [seu_exception_lowpower_tb.sv]
// Self-checking bench for the exception and low-power unit.
`timescale 1ns/100ps
`default_nettype none
module seu_exception_lowpower_tb;
    logic core_clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic global_mask = 1'b1, break_irq = 1'b0, ssr = 1'b0;
    logic [15:0] avs_address = 16'h0000;
    logic [7:0] avs_writedata = 8'h00, avs_readdata;
    logic [6:0] ev = 7'h00;
    logic [19:0] irq_request = 20'h00000, r;
    logic [1:0] op_cmd = 2'h0;
    logic [4:0] vector_sel, v;
    logic avs_waitrequest, reset_request, instr_boundary, swi_exec;
    logic wait_exec, stop_exec, take_exception, stack_pc_minus_one;
    logic in_break, flag_clear_allow, cpu_clk_en, periph_clk_en;
    logic [7:0] exp_rd[$], exp_ex[$];
    int num_errors = 0, n_tests = 0, cyc = 0, n;
    always #10 core_clk = ~core_clk;
    seu_exception_lowpower u_dut (
        .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .por_event(ev[6]),
        .pin_reset_event(ev[5]), .watchdog_reset_event(ev[4]),
        .ill_opcode_event(ev[3]), .ill_address_event(ev[2]),
        .monitor_reset_event(ev[1]), .low_voltage_event(ev[0]),
        .reset_request(reset_request), .instr_boundary(instr_boundary),
        .global_mask(global_mask), .swi_exec(swi_exec),
        .wait_exec(wait_exec), .stop_exec(stop_exec), .break_irq(break_irq),
        .short_stop_recovery_option(ssr), .irq_request(irq_request),
        .take_exception(take_exception), .vector_sel(vector_sel),
        .stack_pc_minus_one(stack_pc_minus_one), .stack_high_index(),
        .clear_global_mask(), .in_break(in_break),
        .flag_clear_allow(flag_clear_allow), .cpu_clk_en(cpu_clk_en),
        .periph_clk_en(periph_clk_en)
    );
    seu_core_model u_core (
        .core_clk(core_clk), .rst(rst), .cpu_clk_en(cpu_clk_en),
        .take_exception(take_exception), .op_cmd(op_cmd),
        .instr_boundary(instr_boundary), .swi_exec(swi_exec),
        .wait_exec(wait_exec), .stop_exec(stop_exec)
    );
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic summarize();
        $display("tests %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic rd(input logic [15:0] a, input logic [7:0] e);
        exp_rd.push_back(e);
        @(posedge core_clk);
        avs_address <= a;
        avs_read <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_read <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge core_clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= 1'b1;
        do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
    endtask
    task automatic issue(input logic [1:0] op);
        @(posedge core_clk);
        op_cmd <= op;
        do @(posedge core_clk); while (instr_boundary !== 1'b1);
        op_cmd <= 2'h0;
    endtask
    task automatic ex_wait();
        while (exp_ex.size() != 0) @(posedge core_clk);
    endtask
    // The watcher also plays the core: entry sets the mask, sources drop.
    always @(posedge core_clk) begin
        if (avs_read && avs_waitrequest === 1'b0)
            chk(avs_readdata, exp_rd.pop_front());
        if (take_exception === 1'b1) begin
            chk({2'b00, stack_pc_minus_one, vector_sel},
                exp_ex.size() != 0 ? exp_ex.pop_front() : 8'hEE);
            global_mask <= 1'b1;
            irq_request <= 20'h00000;
            break_irq <= 1'b0;
        end
    end
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            summarize();
        end
    end
    initial begin
        void'($urandom(36));
        repeat (2) @(posedge core_clk);
        rst <= 1'b0;
        rd(16'hFE01, 8'h80);
        rd(16'hFE01, 8'h00);
        rd(16'hFE00, 8'h00);
        rd(16'hFE02, 8'h00);
        wr(16'hFE03, 8'h80);
        rd(16'hFE03, 8'h80);
        r = 20'($urandom());
        @(posedge core_clk);
        irq_request <= r;
        wr(16'hFE04, 8'hFF);
        rd(16'hFE04, {r[5:0], 2'b00});
        rd(16'hFE05, r[13:6]);
        rd(16'hFE06, {2'b00, r[19:14]});
        for (int i = 0; i < 6; i++) begin
            r = 20'($urandom()) | 20'h80000;
            r[0] = r[0] | (i == 0);
            for (int b = 19; b >= 0; b--) if (r[b]) v = 5'(b + 1);
            exp_ex.push_back({3'b001, v});
            @(posedge core_clk);
            irq_request <= r;
            global_mask <= 1'b0;
            ex_wait();
        end
        exp_ex.push_back(8'h1F);
        issue(2'h1);
        ex_wait();
        issue(2'h2);
        @(negedge core_clk);
        chk({6'h00, cpu_clk_en, periph_clk_en}, 8'h01);
        exp_ex.push_back(8'h23);
        @(posedge core_clk);
        global_mask <= 1'b0;
        irq_request <= 20'h00004;
        ex_wait();
        wr(16'hFE03, 8'h00);
        issue(2'h2);
        exp_ex.push_back(8'h1F);
        @(posedge core_clk);
        break_irq <= 1'b1;
        ex_wait();
        @(negedge core_clk);
        chk({7'h00, flag_clear_allow}, 8'h00);
        wr(16'hFE03, 8'h80);
        @(negedge core_clk);
        chk({7'h00, flag_clear_allow}, 8'h01);
        rd(16'hFE00, 8'h02);
        for (int s = 1; s >= 0; s--) begin
            issue(2'h3);
            exp_ex.push_back(8'h21);
            @(posedge core_clk);
            ssr <= s[0];
            global_mask <= 1'b0;
            irq_request <= 20'h00001;
            @(negedge core_clk);
            chk({7'h00, periph_clk_en}, 8'h00);
            n = 0;
            while (exp_ex.size() != 0) begin
                @(posedge core_clk);
                n++;
            end
            chk(8'(n > (s ? 31 : 4095) && n < (s ? 36 : 4100)), 8'h01);
        end
        for (int i = 0; i < 7; i++) begin
            @(posedge core_clk);
            ev <= 7'h40 >> i;
            @(posedge core_clk);
            chk({7'h00, reset_request}, 8'h01);
            ev <= 7'h00;
            rd(16'hFE01, 8'h80 >> i);
        end
        summarize();
    end
endmodule
`default_nettype wire
